// ===== rtl/pcl_params.svh
// constants for the preset configuration-variable set loader
// Contract
// R1 - value 31 to id variable loads set 31
// R2 - value 32 loads accel, decel, config, 127
// R3 - value 33 adds variable 13 to 32
// R4 - values 47/48 load same, variable 35 differs
// R5 - value 8 restores every variable default
// R6 - address-0 reset restores last loaded set
// R7 - id variable never stores written value
// R8 - id-variable actions only in service mode
// R9 - bit n of variable weighs 2**n
// R10 - decoder and station speed steps agree
// R11 - unknown code leaves all variables unchanged
`ifndef PCL_PARAMS_SVH
`define PCL_PARAMS_SVH

`define PCL_CV_ADDR 8'h01
`define PCL_CV_VER 8'h07
`define PCL_CV_ID 8'h08
`define PCL_CV_CONFIG 8'h1D
`define PCL_CFG_STEP_BIT 1
`define PCL_CODE_FACTORY 8'h08
`define PCL_SET_NONE 8'h00
`define PCL_SET_A 8'h1F
`define PCL_SET_B 8'h20
`define PCL_SET_C 8'h21
`define PCL_SET_D 8'h2F
`define PCL_SET_E 8'h30
`define PCL_SET_LAST_IDX 4'hB
`define PCL_DEF_ADDR 8'h03
`define PCL_DEF_CONFIG 8'h00
`define PCL_DEF_VER 8'h01

`endif

// ===== rtl/pcl_pkg.sv
// types of the preset configuration-variable set loader
package pcl_pkg;
  typedef enum logic [1:0] {
    PCL_IDLE,
    PCL_WIPE,
    PCL_LOAD
  } pcl_state_t;
endpackage

// ===== rtl/pcl_cv_mem.sv
// configuration variable store with registered read data
`timescale 1ns/1ps
module pcl_cv_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// ===== rtl/pcl_loader.sv
// preset configuration-variable set loader with factory and set reset
`timescale 1ns/1ps
`include "pcl_params.svh"
module pcl_loader #(
  parameter logic [7:0] MFR_ID = 8'h5A,  // arbitrary neutral value
  parameter logic [7:0] SW_VER = `PCL_DEF_VER,
  parameter logic [7:0] DEF_ADDR = `PCL_DEF_ADDR,
  parameter logic [7:0] DEF_CONFIG = `PCL_DEF_CONFIG
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_cv_in,
  input wire logic [7:0] wr_data_in,
  input wire logic service_mode_in,
  input wire logic addr0_reset_in,
  input wire logic cs_step128_in,
  input wire logic [7:0] rd_cv_in,
  output logic [7:0] rd_data_out,
  output logic busy_out,
  output logic wr_ack_out,
  output logic wr_reject_out,
  output logic [7:0] active_set_out,
  output logic step128_out,
  output logic step_mismatch_out
);
  pcl_pkg::pcl_state_t state;
  pcl_pkg::pcl_state_t next_state;
  logic [7:0] addr;
  logic [3:0] idx;
  logic [7:0] pending_set;
  logic [7:0] next_pending_set;
  logic [7:0] last_set;
  logic [7:0] next_last_set;

  // one entry of a preset: {variable number, value}; number 0 marks an unused slot
  function automatic logic [15:0] preset_entry(input logic [7:0] set, input logic [3:0] i);
    logic [15:0] e;
    e = 16'h0000;
    case (set)
      `PCL_SET_A: begin  // R1
        case (i)
          4'h0: e = 16'h0201;
          4'h1: e = 16'h0306;
          4'h2: e = 16'h0404;
          4'h3: e = 16'h38B7;
          4'h4: e = 16'h3AFA;
          4'h5: e = 16'h3F46;
          4'h6: e = 16'h7923;
          4'h7: e = 16'h7A0F;
          4'h8: e = 16'h7C18;
          4'h9: e = 16'h7F04;
          default: e = 16'h0000;
        endcase
      end
      `PCL_SET_B, `PCL_SET_C: begin  // R2 R3
        case (i)
          4'h0: e = 16'h0306;
          4'h1: e = 16'h0406;
          4'h2: e = 16'h1D06;
          4'h3: e = 16'h7F14;
          4'h4: e = (set == `PCL_SET_C) ? 16'h0DC3 : 16'h0000;
          default: e = 16'h0000;
        endcase
      end
      `PCL_SET_D, `PCL_SET_E: begin  // R4
        case (i)
          4'h0: e = 16'h0201;
          4'h1: e = 16'h0310;
          4'h2: e = 16'h040D;
          4'h3: e = 16'h05F0;
          4'h4: e = 16'h0678;
          4'h5: e = 16'h0DCC;
          4'h6: e = (set == `PCL_SET_E) ? 16'h2330 : 16'h230C;
          4'h7: e = 16'h3CF0;
          4'h8: e = 16'h3D05;
          4'h9: e = 16'h790C;
          4'hA: e = 16'h7A0A;
          4'hB: e = 16'h7C97;
          default: e = 16'h0000;
        endcase
      end
      default: e = 16'h0000;
    endcase
    return e;
  endfunction

  // factory value of each variable; the id and version variables wipe to the fixed MFR_ID and SW_VER values
  function automatic logic [7:0] default_value(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `PCL_CV_ADDR) begin
      v = DEF_ADDR;
    end else if (a == `PCL_CV_VER) begin
      v = SW_VER;
    end else if (a == `PCL_CV_ID) begin
      v = MFR_ID;
    end else if (a == `PCL_CV_CONFIG) begin
      v = DEF_CONFIG;
    end
    return v;
  endfunction

  // request decode
  wire idle = (state == pcl_pkg::PCL_IDLE);
  wire req = idle && wr_valid_in;
  wire is_id_write = (wr_cv_in == `PCL_CV_ID);
  wire is_set_code = (wr_data_in == `PCL_SET_A) || (wr_data_in == `PCL_SET_B) ||
                     (wr_data_in == `PCL_SET_C) || (wr_data_in == `PCL_SET_D) ||
                     (wr_data_in == `PCL_SET_E);
  wire is_factory = (wr_data_in == `PCL_CODE_FACTORY);
  // address-0 reset wins over a write arriving in the same cycle
  wire take_set_reset = idle && addr0_reset_in;
  wire id_ok = req && !take_set_reset && is_id_write && service_mode_in;  // R8
  wire take_factory = id_ok && is_factory;  // R5
  wire take_set = id_ok && is_set_code;
  // plain writes go to any other variable except variable 0; the id value is never stored
  wire take_plain = req && !take_set_reset && !is_id_write && (wr_cv_in != 8'h00);  // R7
  // unknown code is answered but changes nothing
  wire take_unknown = id_ok && !is_factory && !is_set_code;  // R11
  wire accept = take_factory || take_set || take_plain || take_unknown;
  wire reject = wr_valid_in && !take_set_reset && !accept;

  // store write port
  wire [15:0] entry = preset_entry(pending_set, idx);
  wire entry_used = (entry[15:8] != 8'h00);
  wire wipe_wr = (state == pcl_pkg::PCL_WIPE);
  wire load_wr = (state == pcl_pkg::PCL_LOAD) && entry_used;
  wire mem_wr = wipe_wr || load_wr || take_plain;
  wire [7:0] mem_addr = wipe_wr ? addr : (load_wr ? entry[15:8] : wr_cv_in);
  wire [7:0] mem_data = wipe_wr ? default_value(addr) : (load_wr ? entry[7:0] : wr_data_in);
  wire wipe_done = wipe_wr && (addr == 8'hFF);
  wire load_done = (state == pcl_pkg::PCL_LOAD) && (idx == `PCL_SET_LAST_IDX);
  // speed-step flag is bit 1 of the config variable, weight 2
  wire cfg_wr = mem_wr && (mem_addr == `PCL_CV_CONFIG);
  wire cfg_step = mem_data[`PCL_CFG_STEP_BIT];  // R9

  pcl_cv_mem #(
    .AW(8),
    .DW(8)
  ) u_store (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_en_in(mem_wr),
    .wr_addr_in(mem_addr),
    .wr_data_in(mem_data),
    .rd_addr_in(rd_cv_in),
    .rd_data_out(rd_data_out)
  );

  always_comb begin
    next_state = state;
    next_pending_set = pending_set;
    next_last_set = last_set;
    case (state)
      pcl_pkg::PCL_IDLE: begin
        if (take_set_reset) begin
          // wipe first, then lay the last set over the defaults
          next_state = pcl_pkg::PCL_WIPE;  // R6
          next_pending_set = last_set;  // R6
        end else if (take_factory) begin
          next_state = pcl_pkg::PCL_WIPE;  // R5
          next_pending_set = `PCL_SET_NONE;
          next_last_set = `PCL_SET_NONE;
        end else if (take_set) begin
          next_state = pcl_pkg::PCL_LOAD;
          next_pending_set = wr_data_in;
          next_last_set = wr_data_in;
        end
      end
      pcl_pkg::PCL_WIPE: begin
        if (wipe_done) begin
          if (pending_set == `PCL_SET_NONE) begin
            next_state = pcl_pkg::PCL_IDLE;
          end else begin
            next_state = pcl_pkg::PCL_LOAD;
          end
        end
      end
      pcl_pkg::PCL_LOAD: begin
        if (load_done) begin
          next_state = pcl_pkg::PCL_IDLE;
        end
      end
      default: next_state = pcl_pkg::PCL_IDLE;
    endcase
  end

  // reset starts with a wipe so the store never holds garbage
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= pcl_pkg::PCL_WIPE;
      pending_set <= `PCL_SET_NONE;
      last_set <= `PCL_SET_NONE;
    end else begin
      state <= next_state;
      pending_set <= next_pending_set;
      last_set <= next_last_set;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr <= 8'h00;
      idx <= 4'h0;
    end else begin
      addr <= wipe_wr ? 8'(addr + 8'h01) : 8'h00;
      idx <= (state == pcl_pkg::PCL_LOAD) ? 4'(idx + 4'h1) : 4'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_out <= 1'b1;
      wr_ack_out <= 1'b0;
      wr_reject_out <= 1'b0;
      active_set_out <= `PCL_SET_NONE;
    end else begin
      busy_out <= (next_state != pcl_pkg::PCL_IDLE);
      wr_ack_out <= accept;
      wr_reject_out <= reject;
      active_set_out <= next_last_set;
    end
  end

  // mismatch lets the system warn before lights go dark
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      step128_out <= 1'b0;
      step_mismatch_out <= 1'b0;
    end else begin
      if (cfg_wr) begin
        step128_out <= cfg_step;  // R9
      end
      step_mismatch_out <= (step128_out != cs_step128_in);  // R10
    end
  end
endmodule

// ===== bench/pcl_loader_properties.sv
// port checker for the preset set loader
`timescale 1ns/1ps
module pcl_loader_properties #(parameter logic [7:0] MFR_ID = 8'h5A) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_cv_in,
  input wire logic [7:0] wr_data_in,
  input wire logic service_mode_in,
  input wire logic addr0_reset_in,
  input wire logic cs_step128_in,
  input wire logic [7:0] rd_cv_in,
  input wire logic [7:0] rd_data_out,
  input wire logic busy_out,
  input wire logic wr_ack_out,
  input wire logic wr_reject_out,
  input wire logic [7:0] active_set_out,
  input wire logic step128_out,
  input wire logic step_mismatch_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic prev_req;
  // busy is registered from next_state and tracks the state; the cycle after a request is still kept out of idle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) prev_req <= 1'b1;
    else prev_req <= wr_valid_in | addr0_reset_in;
  end
  wire idle = !busy_out && !prev_req;
  wire take = wr_valid_in && idle && !addr0_reset_in;
  wire id_wr = take && wr_cv_in == 8'h08 && service_mode_in;
  wire set_code = wr_data_in inside {8'h1F, 8'h20, 8'h21, 8'h2F, 8'h30};
  AST_SVC_ONLY:
    assert property (take && wr_cv_in == 8'h08 && !service_mode_in |=> wr_reject_out && !busy_out)
    else $error("id write outside service mode not refused");
  AST_SET_BUSY:
    assert property (id_wr && set_code |=> wr_ack_out ##0 busy_out[*8] ##1 busy_out[*4] ##1 !busy_out)
    else $error("set load busy length wrong");
  AST_SET_CODE:
    assert property (id_wr && set_code |=> active_set_out == $past(wr_data_in))
    else $error("active set code wrong");
  AST_FACTORY:
    assert property (id_wr && wr_data_in == 8'h08 |=> busy_out[*8] ##248 busy_out
      ##1 (!busy_out && active_set_out == 8'h00))
    else $error("factory wipe length or set clear wrong");
  AST_ID_KEEP:
    assert property (rd_cv_in == 8'h08 && idle |=> rd_data_out == MFR_ID)
    else $error("id variable changed");
  AST_ADDR0:
    assert property (addr0_reset_in && idle |=> busy_out[*8])
    else $error("address 0 reset not started");
  AST_UNKNOWN:
    assert property (id_wr && !set_code && wr_data_in != 8'h08
      |=> wr_ack_out && !busy_out && $stable(active_set_out))
    else $error("unknown code changed state");
  AST_STEP_BIT:
    assert property (take && wr_cv_in == 8'h1D |=> step128_out == $past(wr_data_in[1]))
    else $error("step flag not bit 1");
  AST_STEP_AGREE:
    assert property (step_mismatch_out == ($past(step128_out) != $past(cs_step128_in)))
    else $error("step mismatch flag wrong");
endmodule
bind pcl_loader pcl_loader_properties #(.MFR_ID(MFR_ID)) chk (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .wr_valid_in(wr_valid_in),
  .wr_cv_in(wr_cv_in),
  .wr_data_in(wr_data_in),
  .service_mode_in(service_mode_in),
  .addr0_reset_in(addr0_reset_in),
  .cs_step128_in(cs_step128_in),
  .rd_cv_in(rd_cv_in),
  .rd_data_out(rd_data_out),
  .busy_out(busy_out),
  .wr_ack_out(wr_ack_out),
  .wr_reject_out(wr_reject_out),
  .active_set_out(active_set_out),
  .step128_out(step128_out),
  .step_mismatch_out(step_mismatch_out)
);

// ===== bench/pcl_station.sv
// command station model on the programming track
`timescale 1ns/1ps
module pcl_station (
  input wire logic clk_in,
  output logic wr_valid_out,
  output logic [7:0] wr_cv_out,
  output logic [7:0] wr_data_out,
  output logic service_mode_out,
  output logic cs_step128_out
);
  initial begin
    wr_valid_out = 1'b0;
    wr_cv_out = 8'h00;
    wr_data_out = 8'h00;
    service_mode_out = 1'b0;
    cs_step128_out = 1'b0;
  end
  task automatic wr(input logic [7:0] cv, input logic [7:0] data, input logic svc);
    @(posedge clk_in);
    #1;
    service_mode_out = svc;
    wr_cv_out = cv;
    wr_data_out = data;
    wr_valid_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_valid_out = 1'b0;
    // released lines flip rather than hold the last value
    wr_cv_out = ~cv;
    wr_data_out = ~data;
  endtask
  task automatic steps(input logic s128);
    cs_step128_out = s128;
  endtask
endmodule

// ===== bench/test_pcl_loader.sv
// self-checking bench for the preset set loader
`timescale 1ns/1ps
module test_pcl_loader;
  logic clk_in, rstn_in, addr0_reset_in, cs_step128_in, wr_valid_in, service_mode_in;
  logic [7:0] wr_cv_in, wr_data_in, rd_cv_in, rd_data_out, active_set_out;
  logic busy_out, wr_ack_out, wr_reject_out, step128_out, step_mismatch_out;
  int errors, checked;
  pcl_station st (
    .clk_in(clk_in),
    .wr_valid_out(wr_valid_in),
    .wr_cv_out(wr_cv_in),
    .wr_data_out(wr_data_in),
    .service_mode_out(service_mode_in),
    .cs_step128_out(cs_step128_in)
  );
  pcl_loader dut (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wr_valid_in(wr_valid_in),
    .wr_cv_in(wr_cv_in),
    .wr_data_in(wr_data_in),
    .service_mode_in(service_mode_in),
    .addr0_reset_in(addr0_reset_in),
    .cs_step128_in(cs_step128_in),
    .rd_cv_in(rd_cv_in),
    .rd_data_out(rd_data_out),
    .busy_out(busy_out),
    .wr_ack_out(wr_ack_out),
    .wr_reject_out(wr_reject_out),
    .active_set_out(active_set_out),
    .step128_out(step128_out),
    .step_mismatch_out(step_mismatch_out)
  );
  task automatic test_done();
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] cv, input logic [7:0] exp);
    @(posedge clk_in);
    #1;
    rd_cv_in = cv;
    repeat (2) @(posedge clk_in);
    #1;
    chk(rd_data_out, exp);
  endtask
  task automatic idle_wait();
    int n;
    n = 0;
    while (busy_out !== 1'b0) begin
      n++;
      if (n > 400) begin
        errors++;
        $display("Error at %0t: busy %h expected %h", $time, busy_out, 1'b0);
        test_done();
      end
      @(posedge clk_in);
      #1;
    end
  endtask
  task automatic t_set(input logic [7:0] code);
    st.wr(8'h08, code, 1'b1);
    chk({wr_ack_out, busy_out}, 8'h03);
    idle_wait();
    chk(active_set_out, code);
  endtask
  task automatic t_presets();
    t_set(8'h1F);
    rd(8'h38, 8'hB7);
    rd(8'h7C, 8'h18);
    t_set(8'h20);
    rd(8'h04, 8'h06);
    rd(8'h7F, 8'h14);
    t_set(8'h21);
    rd(8'h0D, 8'hC3);
    t_set(8'h2F);
    rd(8'h23, 8'h0C);
    rd(8'h7C, 8'h97);
    t_set(8'h30);
    rd(8'h23, 8'h30);
  endtask
  task automatic t_refuse();
    st.wr(8'h08, 8'h1F, 1'b0);
    chk({wr_reject_out, busy_out}, 8'h02);
    chk(active_set_out, 8'h30);
  endtask
  task automatic t_unknown();
    st.wr(8'h08, 8'h63, 1'b1);
    chk({wr_ack_out, busy_out}, 8'h02);
    rd(8'h23, 8'h30);
    rd(8'h08, 8'h5A);
  endtask
  task automatic t_step();
    // all bits but bit 1 set, so only a wrong weight raises the flag
    st.wr(8'h1D, 8'hFD, 1'b1);
    repeat (3) @(posedge clk_in);
    #1;
    chk({step128_out, step_mismatch_out}, 8'h00);
    st.steps(1'b1);
    repeat (3) @(posedge clk_in);
    #1;
    chk({step128_out, step_mismatch_out}, 8'h01);
    st.wr(8'h1D, 8'h02, 1'b1);
    repeat (3) @(posedge clk_in);
    #1;
    chk({step128_out, step_mismatch_out}, 8'h02);
  endtask
  task automatic t_addr0();
    st.wr(8'h23, 8'h01, 1'b0);
    chk({wr_ack_out, busy_out}, 8'h02);
    @(posedge clk_in);
    #1;
    addr0_reset_in = 1'b1;
    @(posedge clk_in);
    #1;
    addr0_reset_in = 1'b0;
    idle_wait();
    rd(8'h23, 8'h30);
    chk(active_set_out, 8'h30);
  endtask
  task automatic t_factory();
    st.wr(8'h08, 8'h08, 1'b1);
    idle_wait();
    chk(active_set_out, 8'h00);
    rd(8'h23, 8'h00);
    rd(8'h01, 8'h03);
    rd(8'h08, 8'h5A);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    rstn_in = 1'b0;
    addr0_reset_in = 1'b0;
    rd_cv_in = 8'h00;
    errors = 0;
    checked = 0;
    repeat (5) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    @(posedge clk_in);
    #1;
    idle_wait();
    t_presets();
    t_refuse();
    t_unknown();
    t_step();
    t_addr0();
    t_factory();
    test_done();
  end
endmodule
